// [shared/fsr_pkg.sv]
/*
 * Constants for the dual-channel fault and status register block: status bit
 * positions, the layout of the synchronised condition vector, and timing.
 * Assumes a 100 MHz system clock and a serial-bus framing block that supplies
 * read-start, ninth-clock and write-done strobes on the serial clock.
 */
package fsr_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_CH     = 2;
    localparam int STATUS_W   = 8;
    localparam int SNAP_W     = 2 * STATUS_W;

    // ------------------------------------------------------------------
    // Primary status register bit positions
    // ------------------------------------------------------------------
    localparam int PRI_OFF_LSB = 0;
    localparam int PRI_OC_LSB  = 2;
    localparam int PRI_PG_LSB  = 4;
    localparam int PRI_THERMAL = 6;
    localparam int PRI_UV      = 7;

    // ------------------------------------------------------------------
    // Secondary status register bit positions (bits 4 to 7 read zero)
    // ------------------------------------------------------------------
    localparam int SEC_CABLE_LSB = 0;
    localparam int SEC_TONE_LSB  = 2;

    // ------------------------------------------------------------------
    // Layout of the synchronised condition vector
    // ------------------------------------------------------------------
    localparam int RAW_OC_LSB    = 0;
    localparam int RAW_B85_LSB   = 2;
    localparam int RAW_W90_LSB   = 4;
    localparam int RAW_CTEST_LSB = 6;
    localparam int RAW_A21_LSB   = 8;
    localparam int RAW_B1995_LSB = 10;
    localparam int RAW_TONE_LSB  = 12;
    localparam int RAW_OT        = 14;
    localparam int RAW_UV        = 15;
    localparam int RAW_W         = 16;

    // ------------------------------------------------------------------
    // Thresholds of the analog comparators feeding this block
    // ------------------------------------------------------------------
    localparam int PG_SET_PCT     = 85;
    localparam int PG_CLEAR_PCT   = 90;
    localparam int CABLE_SET_MV   = 21000;
    localparam int CABLE_CLEAR_MV = 19950;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ   = 100;
    localparam int OC_TIME_US     = 48000;
    localparam int OC_CYCLES_DEF  = OC_TIME_US * CLK_FREQ_MHZ;

    // ------------------------------------------------------------------
    // Read pointer
    // ------------------------------------------------------------------
    typedef enum logic {
        SEL_PRIMARY,
        SEL_SECONDARY
    } fsr_rd_sel_type;

endpackage

// [hw/fsr_status_regs.sv]
/*
 * Fault and status register block for a two-channel converter supply
 * regulator. Holds the latched and live fault flags, the overcurrent timer
 * and the output enables on the system clock, and serves the two status
 * bytes to the serial-bus framing logic on the serial clock.
 * Assumes: framing logic on link_clk_in gives one-cycle strobes; fault and
 * comparator inputs are asynchronous levels; link clock may stop idle.
 */
// Notes on behaviour
// - Undervoltage, thermal flags stay latched until read and fault gone; overcurrent flags until read.
// - Output-off flag set by fault or disable, latched until output commanded on.
// - Only output-off, power-not-good, tone and cable-open flags clear without a read.
// - Multi-byte reads alternate primary then secondary, each read starts at primary.
// - With all channels enabled, healthy and tone-free, both status bytes read zero.
// - Primary byte: off1, off2, oc1, oc2, png1, png2, thermal, undervoltage.
// - Secondary byte: cable1, cable2, tone1, tone2, upper four bits zero.
// - Output-off flags are set at power-on and on fault shutdown.
// - Output-off flags rising never raise the interrupt request.
// - A write leaving a channel enabled clears its output-off flag.
// - Overcurrent beyond 48 ms turns the output off, sets oc and off flags.
// - Ninth read clock refreshes status and clears overcurrent flags unless a trip lands in the same cycle.
// - Power-not-good sets below 85 percent, clears within 90 percent.
// - Power-not-good reads one whenever the output is disabled.
// - Overtemperature turns both outputs off, sets thermal and both off flags.
// - Thermal flag resamples the condition at the ninth read clock.
// - Undervoltage turns outputs off; only an enable write turns them on.
// - Undervoltage flag resamples the condition at the ninth read clock.
// - Cable-open is live: clears when test off or cable sensed.
// - Cable-open sets above 21 V and clears below 19.95 V during test.
// - Tone-detect follows tone presence at the channel output.
`timescale 1ns/1ps

module fsr_status_regs
    import fsr_pkg::*;
#(
    parameter int OC_CYCLES = OC_CYCLES_DEF
) (
    // System clock and reset
    input  wire logic                mclk_in,
    input  wire logic                reset_n_in,
    // Serial clock and framing strobes
    input  wire logic                link_clk_in,
    input  wire logic                rd_start_in,
    input  wire logic                rd_ninth_in,
    input  wire logic                wr_done_in,
    input  wire logic [NUM_CH-1:0]   wr_enable_in,
    output logic      [STATUS_W-1:0] rd_byte_out,
    // Asynchronous fault and comparator levels
    input  wire logic [NUM_CH-1:0]   overcurrent_in,
    input  wire logic [NUM_CH-1:0]   below_85pct_in,
    input  wire logic [NUM_CH-1:0]   within_90pct_in,
    input  wire logic [NUM_CH-1:0]   cable_test_on_in,
    input  wire logic [NUM_CH-1:0]   above_21v_in,
    input  wire logic [NUM_CH-1:0]   below_19v95_in,
    input  wire logic [NUM_CH-1:0]   tone_present_in,
    input  wire logic                over_temp_in,
    input  wire logic                vin_low_in,
    // Output stage control and interrupt
    output logic      [NUM_CH-1:0]   converter_supply_output_out,
    output logic                     irq_out
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    localparam int CW = $clog2(OC_CYCLES + 1);

    if (OC_CYCLES < 2) begin : g_bad_oc
        $error("OC_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------------
    // Reset release, one synchroniser per domain
    // ------------------------------------------------------------------
    logic [1:0] mrst_sync_reg;
    logic [1:0] lrst_sync_reg;
    logic       mrst_n;
    logic       lrst_n;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mrst_sync_reg <= 2'h0;
        end else begin
            mrst_sync_reg <= {mrst_sync_reg[0], 1'b1};
        end
    end

    always_ff @(posedge link_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lrst_sync_reg <= 2'h0;
        end else begin
            lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
        end
    end

    assign mrst_n = mrst_sync_reg[1];
    assign lrst_n = lrst_sync_reg[1];

    // ------------------------------------------------------------------
    // State of each domain
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [RAW_W-1:0]             raw_s1;
        logic [RAW_W-1:0]             raw_s2;
        logic                         ninth_s1;
        logic                         ninth_s2;
        logic                         ninth_s3;
        logic                         wr_s1;
        logic                         wr_s2;
        logic                         wr_s3;
        logic                         ack_s1;
        logic                         ack_s2;
        logic [NUM_CH-1:0]            enabled;
        logic [NUM_CH-1:0]            oc_flag;
        logic                         thermal_flag;
        logic                         uv_flag;
        logic [NUM_CH-1:0]            power_good;
        logic [NUM_CH-1:0]            cable_open;
        logic [NUM_CH-1:0][CW-1:0]    oc_cnt;
        logic                         pub_tgl;
        logic [SNAP_W-1:0]            pub_data;
        logic                         irq;
    } fsr_sys_state_type;

    typedef struct packed {
        logic                         pub_s1;
        logic                         pub_s2;
        logic                         pub_seen;
        logic [SNAP_W-1:0]            snap;
        logic [STATUS_W-1:0]          byte_out;
        fsr_rd_sel_type               sel;
        logic                         ninth_tgl;
        logic                         wr_tgl;
        logic [NUM_CH-1:0]            wr_en;
    } fsr_link_state_type;

    fsr_sys_state_type  sys_reg;
    fsr_sys_state_type  sys_next;
    fsr_link_state_type lnk_reg;
    fsr_link_state_type lnk_next;

    // Decoded system-side values; all but status2 are also watched by the assertions.
    logic                rd_evt;
    logic                wr_evt;
    logic                ot_now;
    logic                uv_now;
    logic [NUM_CH-1:0]   oc_trip;
    logic [STATUS_W-1:0] status1;
    logic [STATUS_W-1:0] status2;

    // ------------------------------------------------------------------
    // System domain: flags, timer, enables
    // ------------------------------------------------------------------
    always_comb begin
        logic [RAW_W-1:0] r;
        sys_next = sys_reg;
        r        = sys_reg.raw_s2;

        sys_next.raw_s1   = {vin_low_in, over_temp_in, tone_present_in, below_19v95_in,
                             above_21v_in, cable_test_on_in, within_90pct_in,
                             below_85pct_in, overcurrent_in};
        sys_next.raw_s2   = sys_reg.raw_s1;
        sys_next.ninth_s1 = lnk_reg.ninth_tgl;
        sys_next.ninth_s2 = sys_reg.ninth_s1;
        sys_next.ninth_s3 = sys_reg.ninth_s2;
        sys_next.wr_s1    = lnk_reg.wr_tgl;
        sys_next.wr_s2    = sys_reg.wr_s1;
        sys_next.wr_s3    = sys_reg.wr_s2;
        sys_next.ack_s1   = lnk_reg.pub_seen;
        sys_next.ack_s2   = sys_reg.ack_s1;

        rd_evt = sys_reg.ninth_s2 ^ sys_reg.ninth_s3;
        wr_evt = sys_reg.wr_s2 ^ sys_reg.wr_s3;
        ot_now = r[RAW_OT];
        uv_now = r[RAW_UV];

        // The write data is held in the link domain until the next write,
        // which cannot follow within the few system cycles of the crossing.
        if (wr_evt) begin
            sys_next.enabled = lnk_reg.wr_en;
        end

        for (int c = 0; c < NUM_CH; c++) begin
            // The timer runs only while the output is on and overloaded.
            oc_trip[c] = sys_reg.enabled[c] && r[RAW_OC_LSB + c] &&
                         (sys_reg.oc_cnt[c] == CW'(OC_CYCLES - 1));
            if (sys_reg.enabled[c] && r[RAW_OC_LSB + c] && !oc_trip[c]) begin
                sys_next.oc_cnt[c] = sys_reg.oc_cnt[c] + CW'(1);
            end else begin
                sys_next.oc_cnt[c] = '0;
            end

            if (rd_evt) begin
                sys_next.oc_flag[c] = 1'b0;
            end
            if (oc_trip[c]) begin
                sys_next.oc_flag[c] = 1'b1;
                sys_next.enabled[c] = 1'b0;
            end

            if (r[RAW_B85_LSB + c]) begin
                sys_next.power_good[c] = 1'b0;
            end else if (r[RAW_W90_LSB + c]) begin
                sys_next.power_good[c] = 1'b1;
            end

            if (!r[RAW_CTEST_LSB + c] || r[RAW_B1995_LSB + c]) begin
                sys_next.cable_open[c] = 1'b0;
            end else if (r[RAW_A21_LSB + c]) begin
                sys_next.cable_open[c] = 1'b1;
            end
        end

        // A read samples the live condition; a present condition sets anyway.
        if (rd_evt) begin
            sys_next.thermal_flag = ot_now;
            sys_next.uv_flag      = uv_now;
        end
        if (ot_now) begin
            sys_next.thermal_flag = 1'b1;
            sys_next.enabled      = '0;
        end
        if (uv_now) begin
            sys_next.uv_flag      = 1'b1;
            sys_next.enabled      = '0;
        end

        // Output-off flags are left out, so deliberate disables stay quiet.
        sys_next.irq = (|sys_next.oc_flag) | sys_next.thermal_flag |
                       sys_next.uv_flag;

        status1 = '0;
        status2 = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            status1[PRI_OFF_LSB + c] = !sys_reg.enabled[c];
            status1[PRI_OC_LSB + c]  = sys_reg.oc_flag[c];
            status1[PRI_PG_LSB + c]  = !sys_reg.enabled[c] ||
                                       !sys_reg.power_good[c];
            status2[SEC_CABLE_LSB + c] = sys_reg.cable_open[c];
            status2[SEC_TONE_LSB + c]  = r[RAW_TONE_LSB + c];
        end
        status1[PRI_THERMAL] = sys_reg.thermal_flag;
        status1[PRI_UV]      = sys_reg.uv_flag;

        // Publish a new word only once the last one has been acknowledged.
        if ((sys_reg.ack_s2 == sys_reg.pub_tgl) &&
            ({status2, status1} != sys_reg.pub_data)) begin
            sys_next.pub_data = {status2, status1};
            sys_next.pub_tgl  = !sys_reg.pub_tgl;
        end
    end

    always_ff @(posedge mclk_in or negedge mrst_n) begin
        if (!mrst_n) begin
            sys_reg <= '0;
        end else begin
            sys_reg <= sys_next;
        end
    end

    assign converter_supply_output_out = sys_reg.enabled;
    assign irq_out                     = sys_reg.irq;

    // ------------------------------------------------------------------
    // Link domain: snapshot and byte pointer
    // ------------------------------------------------------------------
    always_comb begin
        lnk_next        = lnk_reg;
        lnk_next.pub_s1 = sys_reg.pub_tgl;
        lnk_next.pub_s2 = lnk_reg.pub_s1;
        if (lnk_reg.pub_s2 != lnk_reg.pub_seen) begin
            lnk_next.snap     = sys_reg.pub_data;
            lnk_next.pub_seen = lnk_reg.pub_s2;
        end

        if (rd_start_in) begin
            lnk_next.byte_out = lnk_reg.snap[STATUS_W-1:0];
            lnk_next.sel      = SEL_SECONDARY;
        end else if (rd_ninth_in) begin
            lnk_next.ninth_tgl = !lnk_reg.ninth_tgl;
            case (lnk_reg.sel)
                SEL_PRIMARY: begin
                    lnk_next.byte_out = lnk_reg.snap[STATUS_W-1:0];
                    lnk_next.sel      = SEL_SECONDARY;
                end
                SEL_SECONDARY: begin
                    lnk_next.byte_out = lnk_reg.snap[SNAP_W-1:STATUS_W];
                    lnk_next.sel      = SEL_PRIMARY;
                end
                default: begin
                    lnk_next.sel = SEL_PRIMARY;
                end
            endcase
        end

        if (wr_done_in) begin
            lnk_next.wr_en  = wr_enable_in;
            lnk_next.wr_tgl = !lnk_reg.wr_tgl;
        end
    end

    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            lnk_reg <= '0;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    assign rd_byte_out = lnk_reg.byte_out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_oc_trip_off: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        oc_trip[0] |=> sys_reg.oc_flag[0] && !sys_reg.enabled[0] && status1[PRI_OFF_LSB])
        else $error("overcurrent trip did not set flags or turn output off");

    a_oc_read_clr: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        rd_evt && !oc_trip[1] |=> !sys_reg.oc_flag[1])
        else $error("overcurrent flag survived a read");

    a_latch_hold: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        !rd_evt && sys_reg.thermal_flag |=> sys_reg.thermal_flag && sys_reg.irq)
        else $error("thermal flag dropped without a read");

    a_thermal_sample: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        rd_evt |=> sys_reg.thermal_flag == $past(ot_now))
        else $error("thermal flag not resampled at read");

    a_uv_sample: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        rd_evt |=> sys_reg.uv_flag == $past(uv_now))
        else $error("undervoltage flag not resampled at read");

    a_thermal_off: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        ot_now |=> sys_reg.enabled == '0 && status1[PRI_THERMAL])
        else $error("thermal fault left an output on");

    a_uv_stays_off: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        !sys_reg.enabled[0] && !wr_evt |=> !sys_reg.enabled[0])
        else $error("output re-enabled without a write");

    a_write_enable: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        wr_evt && lnk_reg.wr_en[0] && !ot_now && !uv_now && !oc_trip[0]
        |=> !status1[PRI_OFF_LSB])
        else $error("enable write left output-off flag set");

    a_pg_disabled: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        !sys_reg.enabled[1] |-> status1[PRI_PG_LSB + 1])
        else $error("power-not-good low while output disabled");

    a_irq_quiet: assert property (@(posedge mclk_in) disable iff (!mrst_n)
        sys_reg.oc_flag == '0 && !sys_reg.thermal_flag && !sys_reg.uv_flag |-> !irq_out)
        else $error("interrupt raised without a latched fault");

    a_read_restart: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
        rd_start_in |=> rd_byte_out == $past(lnk_reg.snap[STATUS_W-1:0]))
        else $error("new read did not start with the primary register");

    a_read_order: assert property (@(posedge link_clk_in) disable iff (!lrst_n)
        rd_ninth_in && !rd_start_in && lnk_reg.sel == SEL_SECONDARY
        |=> rd_byte_out == $past(lnk_reg.snap[SNAP_W-1:STATUS_W]))
        else $error("second read byte is not the secondary register");

    c_oc_trip:    cover property (@(posedge mclk_in) disable iff (!mrst_n) oc_trip[0]);
    c_read_clear: cover property (@(posedge mclk_in) disable iff (!mrst_n)
        sys_reg.thermal_flag && rd_evt && !ot_now);
    c_enable:     cover property (@(posedge mclk_in) disable iff (!mrst_n)
        wr_evt && lnk_reg.wr_en == '1);
    c_two_bytes:  cover property (@(posedge link_clk_in) disable iff (!lrst_n)
        rd_start_in ##8 rd_ninth_in ##8 rd_ninth_in);

endmodule

// [verification/fsr_master_model.sv]
/* Serial bus master model: frames reads and writes on its own link clock.
   Assumes the status block samples its strobes on rising link clock edges. */
`timescale 1ns/1ps
module fsr_master_model (
    // Link side
    output logic            link_clk_out,
    output logic            rd_start_out,
    output logic            rd_ninth_out,
    output logic            wr_done_out,
    output logic      [1:0] wr_enable_out,
    input  wire logic [7:0] rd_byte_in
);
    // The clock stands still low between frames, as a real master leaves it.
    initial begin
        link_clk_out  = 1'b0;
        rd_start_out  = 1'b0;
        rd_ninth_out  = 1'b0;
        wr_done_out   = 1'b0;
        wr_enable_out = 2'h0;
    end
    task automatic tick(input int n);
        repeat (n) begin
            #80 link_clk_out = 1'b1;
            #80 link_clk_out = 1'b0;
        end
    endtask
    task automatic ninth(output logic [7:0] b);
        tick(7);
        rd_ninth_out = 1'b1;
        tick(1);
        rd_ninth_out = 1'b0;
        b = rd_byte_in;
    endtask
    // An address phase first gives the snapshot handshake link edges to run.
    // Each frame starts 23 ns off the system clock's grid, at the same phase each time.
    task automatic rd(output logic [7:0] p, output logic [7:0] s, output logic [7:0] q);
        #23;
        tick(9);
        rd_start_out = 1'b1;
        tick(1);
        rd_start_out = 1'b0;
        p = rd_byte_in;
        ninth(s);
        ninth(q);
        tick(2);
    endtask
    task automatic wr(input logic [1:0] en);
        #23;
        tick(9);
        wr_enable_out = en;
        wr_done_out   = 1'b1;
        tick(1);
        wr_done_out   = 1'b0;
        wr_enable_out = ~en;
        tick(2);
    endtask
endmodule

// [verification/tb_top.sv]
/* Self-checking bench for the status register block.
   Assumes the master model frames all link traffic. */
`timescale 1ns/1ps
module tb_top
    import fsr_pkg::*;
;
    logic mclk_in, reset_n_in, link_clk_in, rd_start_in, rd_ninth_in, wr_done_in;
    logic over_temp_in, vin_low_in, irq_out;
    logic [NUM_CH-1:0] wr_enable_in, overcurrent_in, below_85pct_in, within_90pct_in;
    logic [NUM_CH-1:0] cable_test_on_in, above_21v_in, below_19v95_in, tone_present_in;
    logic [NUM_CH-1:0] converter_supply_output_out;
    logic [STATUS_W-1:0] rd_byte_out, p, s, q;
    int bad_count = 0;
    int checked = 0;
    fsr_status_regs #(.OC_CYCLES(20)) DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .link_clk_in(link_clk_in), .rd_start_in(rd_start_in), .rd_ninth_in(rd_ninth_in),
        .wr_done_in(wr_done_in), .wr_enable_in(wr_enable_in), .rd_byte_out(rd_byte_out),
        .overcurrent_in(overcurrent_in), .below_85pct_in(below_85pct_in),
        .within_90pct_in(within_90pct_in), .cable_test_on_in(cable_test_on_in),
        .above_21v_in(above_21v_in), .below_19v95_in(below_19v95_in),
        .tone_present_in(tone_present_in), .over_temp_in(over_temp_in),
        .vin_low_in(vin_low_in), .converter_supply_output_out(converter_supply_output_out),
        .irq_out(irq_out));
    fsr_master_model u_mst (.link_clk_out(link_clk_in), .rd_start_out(rd_start_in),
        .rd_ninth_out(rd_ninth_in), .wr_done_out(wr_done_in),
        .wr_enable_out(wr_enable_in), .rd_byte_in(rd_byte_out));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic rd;
        u_mst.rd(p, s, q);
        w(1);
    endtask
    task automatic pins(input logic i, input logic [1:0] o);
        chk({5'h00, irq_out, converter_supply_output_out}, {5'h00, i, o});
    endtask
    task automatic en_all;
        u_mst.wr(2'b11);
        w(8);
        pins(1'b0, 2'b11);
    endtask
    // Re-reads until the primary byte settles, giving up after eight frames.
    task automatic poll(input logic [7:0] exp);
        for (int k = 0; k < 8; k++) begin
            rd();
            if (p === exp) break;
        end
        chk(p, exp);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd();
        chk(p, 8'h33);
        chk(s, 8'h00);
        chk(q, 8'h33);
        pins(1'b0, 2'b00);
        en_all();
        rd();
        chk(p, 8'h00);
        chk(s, 8'h00);
    endtask
    task automatic t_link;
        cable_test_on_in = 2'b11;
        above_21v_in = 2'b01;
        below_19v95_in = 2'b10;
        tone_present_in = 2'b10;
        w(4);
        rd();
        chk(s, 8'h09);
        chk(q, 8'h00);
        cable_test_on_in = 2'b00;
        tone_present_in = 2'b00;
        w(4);
        rd();
        chk(s, 8'h00);
    endtask
    task automatic t_png;
        below_85pct_in = 2'b01;
        within_90pct_in = 2'b10;
        w(4);
        rd();
        chk(p, 8'h10);
        below_85pct_in = 2'b00;
        w(4);
        rd();
        chk(p, 8'h10);
        within_90pct_in = 2'b11;
        w(4);
        rd();
        chk(p, 8'h00);
    endtask
    task automatic t_ocp;
        overcurrent_in = 2'b01;
        w(40);
        pins(1'b1, 2'b10);
        overcurrent_in = 2'b00;
        w(4);
        rd();
        chk(p, 8'h15);
        rd();
        chk(p, 8'h11);
        pins(1'b0, 2'b10);
        en_all();
    endtask
    task automatic t_temp;
        over_temp_in = 1'b1;
        w(6);
        pins(1'b1, 2'b00);
        rd();
        rd();
        chk(p, 8'h73);
        over_temp_in = 1'b0;
        w(4);
        rd();
        chk(p, 8'h73);
        rd();
        chk(p, 8'h33);
        pins(1'b0, 2'b00);
        en_all();
    endtask
    task automatic t_uv;
        vin_low_in = 1'b1;
        w(6);
        vin_low_in = 1'b0;
        w(4);
        pins(1'b1, 2'b00);
        rd();
        chk(p, 8'hB3);
        poll(8'h33);
        pins(1'b0, 2'b00);
        en_all();
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (100000) @(posedge mclk_in);
        bad_count++;
        conclude();
    end
    initial begin
        {reset_n_in, overcurrent_in, below_85pct_in, cable_test_on_in} = 7'h40;
        {above_21v_in, tone_present_in, over_temp_in, vin_low_in} = 6'h00;
        within_90pct_in = 2'b11;
        below_19v95_in = 2'b11;
        // A clean falling edge clears both domains at once, link clock idle.
        #1 reset_n_in = 1'b0;
        w(12);
        reset_n_in = 1'b1;
        t_reset();
        t_link();
        t_png();
        t_ocp();
        t_temp();
        t_uv();
        conclude();
    end
endmodule
